// >>> common/sapc_pkg.sv
// package: constants, register map and types of the converter control
package sapc_pkg;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned REF_STAB_NS = 14000;
    localparam int unsigned REF_STAB_CYC =
        (REF_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RES_BITS = 10;
    localparam int unsigned CH_NUM = 4;
    localparam int unsigned STEPS_PER_CONV = 12;
    // register indices, byte address is four times the index
    localparam logic [5:0] IDX_RESULT = 6'h08;
    localparam logic [5:0] IDX_MODE = 6'h28;
    localparam logic [5:0] IDX_CHSEL = 6'h29;
    localparam logic [5:0] IDX_PFMODE = 6'h2a;
    localparam logic [5:0] IDX_PFTHR = 6'h2b;
    localparam logic [5:0] IDX_STATUS = 6'h2c;
    // field positions
    localparam int unsigned MODE_EN_BIT = 7;
    localparam int unsigned MODE_FR_LSB = 3;
    localparam int unsigned MODE_REF_BIT = 0;
    localparam int unsigned PF_EN_BIT = 7;
    localparam int unsigned PF_LT_BIT = 6;
    localparam int unsigned RES_LSB = 6;
    localparam logic [7:0] MODE_WMASK = 8'hb9;
    localparam logic [7:0] PFMODE_WMASK = 8'hc0;
    // reset values
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [1:0] CHSEL_RST = 2'h0;
    localparam logic [7:0] PFMODE_RST = 8'h00;
    localparam logic [7:0] PFTHR_RST = 8'h00;
    // clocks per approximation step, one twelfth of the conversion time
    localparam logic [4:0] STEP_288 = 5'h18;
    localparam logic [4:0] STEP_240 = 5'h14;
    localparam logic [4:0] STEP_192 = 5'h10;
    localparam logic [4:0] STEP_144 = 5'h0c;
    localparam logic [4:0] STEP_120 = 5'h0a;
    localparam logic [4:0] STEP_96 = 5'h08;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SAMP = 4'h2,
        ST_CONV = 4'h4,
        ST_DONE = 4'h8
    } sapc_state_t;

    function automatic logic [4:0] step_cycles(input logic [2:0] fr);
        case (fr)
            3'h1: step_cycles = STEP_240;
            3'h2: step_cycles = STEP_192;
            3'h4: step_cycles = STEP_144;
            3'h5: step_cycles = STEP_120;
            3'h6: step_cycles = STEP_96;
            default: step_cycles = STEP_288;
        endcase
    endfunction
endpackage

// >>> common/sapc_sar_if.sv
// interface: control lines between sequencer and approximation register
`timescale 1ns/1ps
`default_nettype none
interface sapc_sar_if;
    logic clr;
    logic start;
    logic decide;
    logic cmp;
    logic [sapc_pkg::RES_BITS-1:0] trial;
    modport ctl (output clr, output start, output decide, output cmp, input trial);
    modport sar (input clr, input start, input decide, input cmp, output trial);
endinterface
`default_nettype wire

// >>> rtl/sapc_sync.sv
// module: three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sapc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] out_r;
    logic [WIDTH-1:0] agree_w;
    logic [WIDTH-1:0] out_nxt;

    if (WIDTH < 1) begin : g_bad_width
        $error("sapc_sync: WIDTH must be at least 1");
    end

    assign agree_w = ~(s2_r ^ s3_r);
    assign out_nxt = (s3_r & agree_w) | (out_r & ~agree_w);
    assign sync_o = out_r;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else if (ce_i) begin
            s1_r <= async_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= out_nxt;
        end
    end
endmodule // sapc_sync
`default_nettype wire

// >>> rtl/sapc_sar.sv
// module: successive-approximation register, msb first
`timescale 1ns/1ps
`default_nettype none
module sapc_sar
    import sapc_pkg::*;
#(
    parameter int unsigned BITS = sapc_pkg::RES_BITS
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    sapc_sar_if.sar sar_io
);
    logic [BITS-1:0] sar_r;
    logic [BITS-1:0] mask_r;
    logic [BITS-1:0] sar_nxt;
    logic [BITS-1:0] mask_nxt;
    logic [BITS-1:0] kept_w;
    logic [BITS-1:0] msb_w;

    if (BITS != RES_BITS) begin : g_bad_bits
        $error("sapc_sar: BITS must equal RES_BITS");
    end

    assign msb_w = {1'b1, {(BITS-1){1'b0}}};
    // trial bit stays when the input is not below the trial level
    assign kept_w = sar_io.cmp ? sar_r : (sar_r & ~mask_r);
    assign mask_nxt = sar_io.clr ? '0 :
                      sar_io.start ? msb_w :
                      sar_io.decide ? (mask_r >> 1) : mask_r;
    assign sar_nxt = sar_io.clr ? '0 :
                     sar_io.start ? msb_w :
                     sar_io.decide ? (kept_w | (mask_r >> 1)) : sar_r;
    assign sar_io.trial = sar_r;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sar_r <= '0;
            mask_r <= '0;
        end else if (ce_i) begin
            sar_r <= sar_nxt;
            mask_r <= mask_nxt;
        end
    end
endmodule // sapc_sar
`default_nettype wire

// >>> rtl/sapc_top.sv
// module: converter sequencer, register file and power-fail compare
// Summary of operation
// - four inputs, ten-bit result per conversion
// - enabled converter repeats on selected channel
// - interrupt after every finished conversion except a discarded first one or a power-fail mismatch
// - power-fail mode interrupts only on match
// - unselected pins stay digital inputs
// - sample at start, hold until end
// - approximation msb first, one bit per step
// - after lsb, copy approximation to result
// - result left-aligned, low six bits zero
// - mode register sets time and run
// - channel register picks sampled input
// - power-fail mode register sets comparison
// - threshold register holds comparison value
// - enable bit stops or runs conversion
// - time codes give 288 to 96 clocks
// - two-bit channel field, upper bits zero
// - first result invalid without stable reference
`timescale 1ns/1ps
`default_nettype none
module sapc_top
    import sapc_pkg::*;
#(
    parameter int unsigned NUM_CH = sapc_pkg::CH_NUM
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic cmp_i,
    input wire logic [NUM_CH-1:0] port_pin_i,
    output logic sample_o,
    output logic [sapc_pkg::RES_BITS-1:0] trial_o,
    output logic [1:0] chan_o,
    output logic ref_en_o,
    output logic [NUM_CH-1:0] analog_sel_o,
    output logic [NUM_CH-1:0] digital_en_o,
    output logic conversion_irq_o
);
    import sapc_pkg::*;

    if (NUM_CH != CH_NUM) begin : g_bad_ch
        $error("sapc_top: NUM_CH must equal CH_NUM");
    end

    localparam int unsigned REF_W = $clog2(REF_STAB_CYC + 1);
    localparam logic [REF_W-1:0] REF_DONE = REF_W'(REF_STAB_CYC);
    localparam logic [3:0] LAST_BIT = 4'(RES_BITS - 1);

    sapc_sar_if sar_if ();

    // bus slave state
    logic ack_r;
    logic [31:0] rdata_r;
    logic req_w;
    logic wr_go_w;
    logic [5:0] idx_w;
    logic be0_w;
    logic hit_res_w;
    logic hit_mode_w;
    logic hit_chsel_w;
    logic hit_pfm_w;
    logic hit_pft_w;
    logic hit_stat_w;
    logic [31:0] rd_mux_w;

    // software registers
    logic [7:0] mode_r;
    logic [1:0] chsel_r;
    logic [7:0] pfm_r;
    logic [7:0] pft_r;
    logic [RES_BITS-1:0] result_r;
    logic [7:0] wbyte_w;

    // sequencer
    sapc_state_t st_r;
    sapc_state_t st_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic [3:0] bit_r;
    logic [3:0] bit_nxt;
    logic en_w;
    logic en_q_r;
    logic en_rise_w;
    logic [2:0] fr_w;
    logic [4:0] step_w;
    logic [5:0] samp_load_w;
    logic [5:0] step_load_w;
    logic load_w;
    logic done_st_w;
    logic irq_r;

    // reference generator and power-fail compare
    logic [REF_W-1:0] ref_cnt_r;
    logic ref_rdy_w;
    logic discard_r;
    logic [7:0] res_hi_w;
    logic pf_en_w;
    logic pf_lt_w;
    logic cond_w;
    logic cmp_s_w;
    logic [NUM_CH-1:0] pin_s_w;
    logic [NUM_CH-1:0] sel_oh_w;

    sapc_sync #(.WIDTH(1)) u_cmp_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .async_i(cmp_i),
        .sync_o(cmp_s_w)
    );

    sapc_sync #(.WIDTH(NUM_CH)) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .async_i(port_pin_i),
        .sync_o(pin_s_w)
    );

    sapc_sar #(.BITS(RES_BITS)) u_sar (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .sar_io(sar_if.sar)
    );

    // bus decode, one wait state per access
    assign req_w = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = req_w & ~(ack_r & ce_i);
    assign wr_go_w = avs_write_i & ack_r & ce_i;
    assign idx_w = avs_address_i[7:2];
    assign be0_w = avs_byteenable_i[0];
    assign wbyte_w = avs_writedata_i[7:0];
    assign hit_res_w = idx_w == IDX_RESULT;
    assign hit_mode_w = idx_w == IDX_MODE;
    assign hit_chsel_w = idx_w == IDX_CHSEL;
    assign hit_pfm_w = idx_w == IDX_PFMODE;
    assign hit_pft_w = idx_w == IDX_PFTHR;
    assign hit_stat_w = idx_w == IDX_STATUS;
    assign rd_mux_w =
        hit_res_w ? {16'h0000, result_r, 6'h00} :
        hit_mode_w ? {24'h000000, mode_r} :
        hit_chsel_w ? {30'h00000000, chsel_r} :
        hit_pfm_w ? {24'h000000, pfm_r} :
        hit_pft_w ? {24'h000000, pft_r} :
        hit_stat_w ? {24'h000000, pin_s_w & ~sel_oh_w, 1'b0, discard_r,
                      ref_rdy_w, ~st_r[0]} :
        32'h00000000;
    assign avs_readdata_o = rdata_r;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else if (ce_i) begin
            ack_r <= req_w & ~ack_r;
            if (req_w && !ack_r) begin
                rdata_r <= rd_mux_w;
            end
        end
    end

    // software register writes, byte lane 0
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r <= MODE_RST;
            chsel_r <= CHSEL_RST;
            pfm_r <= PFMODE_RST;
            pft_r <= PFTHR_RST;
        end else if (wr_go_w && be0_w) begin
            if (hit_mode_w) mode_r <= wbyte_w & MODE_WMASK;
            if (hit_chsel_w) chsel_r <= wbyte_w[1:0];
            if (hit_pfm_w) pfm_r <= wbyte_w & PFMODE_WMASK;
            if (hit_pft_w) pft_r <= wbyte_w;
        end
    end

    // mode fields
    assign en_w = mode_r[MODE_EN_BIT];
    assign fr_w = mode_r[MODE_FR_LSB +: 3];
    assign step_w = step_cycles(fr_w);
    assign samp_load_w = {step_w, 1'b0} - 6'h02;
    assign step_load_w = {1'b0, step_w} - 6'h01;
    assign en_rise_w = en_w & ~en_q_r;

    // reference generator settling
    assign ref_en_o = mode_r[MODE_REF_BIT];
    assign ref_rdy_w = ref_cnt_r == REF_DONE;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_cnt_r <= '0;
            en_q_r <= 1'b0;
            discard_r <= 1'b0;
        end else if (ce_i) begin
            en_q_r <= en_w;
            if (!ref_en_o) ref_cnt_r <= '0;
            else if (!ref_rdy_w) ref_cnt_r <= ref_cnt_r + 1'b1;
            if (en_rise_w && !ref_rdy_w) discard_r <= 1'b1;
            else if (done_st_w || !en_w) discard_r <= 1'b0;
        end
    end

    // channel routing, unselected pins stay digital
    assign sel_oh_w = en_w ? NUM_CH'(1) << chsel_r : '0;
    assign analog_sel_o = sel_oh_w;
    assign digital_en_o = ~sel_oh_w;
    assign chan_o = chsel_r;

    // sequencer: sample, ten steps, one result cycle
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        bit_nxt = bit_r;
        unique case (st_r)
            ST_IDLE: begin
                if (en_w) begin
                    st_nxt = ST_SAMP;
                    cnt_nxt = samp_load_w;
                end
            end
            ST_SAMP: begin
                if (cnt_r == 6'h00) begin
                    st_nxt = ST_CONV;
                    cnt_nxt = step_load_w;
                    bit_nxt = 4'h0;
                end else begin
                    cnt_nxt = cnt_r - 6'h01;
                end
            end
            ST_CONV: begin
                if (cnt_r != 6'h00) begin
                    cnt_nxt = cnt_r - 6'h01;
                end else if (bit_r == LAST_BIT) begin
                    st_nxt = ST_DONE;
                end else begin
                    cnt_nxt = step_load_w;
                    bit_nxt = bit_r + 4'h1;
                end
            end
            ST_DONE: begin
                st_nxt = ST_SAMP;
                cnt_nxt = samp_load_w;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        if (!en_w) begin
            st_nxt = ST_IDLE;
        end
    end

    assign sar_if.clr = ~en_w;
    assign sar_if.start = (st_r == ST_SAMP) & (cnt_r == 6'h00) & en_w;
    assign sar_if.decide = (st_r == ST_CONV) & (cnt_r == 6'h00) & en_w;
    assign sar_if.cmp = cmp_s_w;
    assign sample_o = st_r == ST_SAMP;
    assign trial_o = sar_if.trial;

    // result load and interrupt decision
    assign done_st_w = (st_r == ST_DONE) & en_w;
    assign load_w = done_st_w & ~discard_r;
    assign res_hi_w = sar_if.trial[RES_BITS-1 -: 8];
    assign pf_en_w = pfm_r[PF_EN_BIT];
    assign pf_lt_w = pfm_r[PF_LT_BIT];
    assign cond_w = ~pf_en_w | (pf_lt_w ? (res_hi_w < pft_r) : (res_hi_w >= pft_r));
    assign conversion_irq_o = irq_r;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= ST_IDLE;
            cnt_r <= 6'h00;
            bit_r <= 4'h0;
            result_r <= '0;
            irq_r <= 1'b0;
        end else if (ce_i) begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            bit_r <= bit_nxt;
            if (load_w) result_r <= sar_if.trial;
            irq_r <= load_w & cond_w;
        end
    end

    // checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    irq_pulse_a: assert property ((irq_r && ce_i) |=> !irq_r)
        else $error("interrupt longer than one cycle");
    irq_cause_a: assert property (($rose(irq_r)) |-> $past(load_w && cond_w))
        else $error("interrupt without finished conversion");
    pf_gate_a: assert property ((ce_i && load_w && pf_en_w && !cond_w) |=> !irq_r)
        else $error("interrupt despite failed comparison");
    stop_idle_a: assert property ((ce_i && !en_w) |=> (st_r == ST_IDLE && !irq_r))
        else $error("conversion not abandoned on disable");
    sample_hold_a: assert property ((st_r == ST_CONV) |-> !sample_o)
        else $error("sample active during approximation");
    msb_first_a: assert property ((ce_i && sar_if.start) |=> (trial_o == 10'h200))
        else $error("approximation does not start at msb");
    result_load_a: assert property ((ce_i && load_w) |=> (result_r == $past(trial_o)))
        else $error("result not copied from approximation");
    repeat_conv_a: assert property ((ce_i && done_st_w) |=> (st_r == ST_SAMP))
        else $error("conversion not repeated");
    discard_first_a: assert property ((ce_i && done_st_w && discard_r) |=> !irq_r)
        else $error("first result used without stable reference");
    chan_route_a: assert property (en_w |-> (analog_sel_o[chan_o] && !digital_en_o[chan_o]))
        else $error("selected channel not routed");

    irq_seen_c: cover property (ce_i && load_w && cond_w);
    pf_block_c: cover property (ce_i && load_w && pf_en_w && !cond_w);
    discard_c: cover property (ce_i && done_st_w && discard_r);
    abort_c: cover property ((st_r == ST_CONV) && !en_w);
endmodule // sapc_top
`default_nettype wire

// >>> verification/sapc_afe_model.sv
// model: sample-hold, resistor string and comparator of the front end
`timescale 1ns/1ps
`default_nettype none
module sapc_afe_model (
    input wire logic clk_sys_i,
    input wire logic sample_i,
    input wire logic [1:0] chan_i,
    input wire logic [9:0] trial_i,
    input wire logic [39:0] level_i,
    output logic cmp_o
);
    logic [9:0] held_r = 10'h000;
    // track while sampling, hold otherwise
    always @(posedge clk_sys_i) begin
        if (sample_i === 1'b1) begin
            held_r <= level_i[chan_i*10 +: 10];
        end
    end
    // ideal comparator against the trial level
    assign cmp_o = (held_r >= trial_i);
endmodule // sapc_afe_model
`default_nettype wire

// >>> verification/tb_top.sv
// testbench: bus driver, front-end model and reference checks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sapc_pkg::*;
    localparam logic [7:0] A_RES = {IDX_RESULT, 2'b00};
    localparam logic [7:0] A_MODE = {IDX_MODE, 2'b00};
    localparam logic [7:0] A_CHS = {IDX_CHSEL, 2'b00};
    localparam logic [7:0] A_PFM = {IDX_PFMODE, 2'b00};
    localparam logic [7:0] A_PFT = {IDX_PFTHR, 2'b00};
    localparam logic [7:0] A_STS = {IDX_STATUS, 2'b00};
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cmp;
    logic sample;
    logic ref_en;
    logic irq;
    logic [3:0] port_pin = 4'h0;
    logic [9:0] trial;
    logic [1:0] chan;
    logic [3:0] analog_sel;
    logic [3:0] digital_en;
    logic [39:0] levels = 40'h0;
    logic ce = 1'b1;
    logic [31:0] rd;
    logic [9:0] v;
    int err_total = 0;
    int n_tests = 0;
    int n;
    int s;

    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    sapc_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
        .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
        .avs_writedata_i(avs_writedata), .avs_byteenable_i(4'h1),
        .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest),
        .cmp_i(cmp), .port_pin_i(port_pin), .sample_o(sample), .trial_o(trial),
        .chan_o(chan), .ref_en_o(ref_en), .analog_sel_o(analog_sel),
        .digital_en_o(digital_en), .conversion_irq_o(irq));

    sapc_afe_model u_afe (.clk_sys_i(clk_sys_i), .sample_i(sample), .chan_i(chan),
        .trial_i(trial), .level_i(levels), .cmp_o(cmp));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input bit wr, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] q);
        int k;
        k = 0;
        @(posedge clk_sys_i);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        do begin
            @(posedge clk_sys_i);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        if (avs_waitrequest !== 1'b0) begin
            err_total++;
            complete_run();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 8'h00, q);
        chk(what, exp, q);
    endtask

    // count cycles up to the next interrupt, and sampling cycles on the way
    task automatic wait_irq(input int lim, output int c, output int sc);
        c = 0;
        sc = 0;
        do begin
            @(negedge clk_sys_i);
            c++;
            if (sample === 1'b1) sc++;
        end while (irq !== 1'b1 && c < lim);
    endtask

    // one channel and time code: period, sampling, selection, result
    task automatic run_conv(input int code, input int ch);
        int step;
        logic [9:0] lv;
        step = (code == 0) ? 24 : (code == 1) ? 20 : (code == 2) ? 16 :
               (code == 4) ? 12 : (code == 5) ? 10 : 8;
        lv = 10'($urandom_range(1023));
        levels[ch*10 +: 10] = lv;
        wr_reg(A_CHS, 8'(ch));
        port_pin <= 4'($urandom);
        wr_reg(A_MODE, 8'h81 | 8'(code << 3));
        wait_irq(400, n, s);
        chk("first_irq", 32'h1, {31'h0, irq});
        wait_irq(400, n, s);
        chk("period", 32'(12 * step), 32'(n));
        chk("sample_len", 32'(2 * step - 1), 32'(s));
        chk("analog_sel", {28'h0, 4'h1 << ch}, {28'h0, analog_sel});
        chk("digital_en", {28'h0, ~(4'h1 << ch)}, {28'h0, digital_en});
        @(negedge clk_sys_i);
        chk("irq_width", 32'h0, {31'h0, irq});
        rd_chk("result", A_RES, {16'h0, lv, 6'h00});
        rd_chk("status", A_STS, {24'h0, port_pin & ~(4'h1 << ch), 4'h3});
        wr_reg(A_MODE, 8'h01);
        @(negedge clk_sys_i);
        chk("idle_sel", 32'h0, {28'h0, analog_sel});
        $display("test conv code %0d chan %0d done", code, ch);
    endtask

    initial begin
        #(10 * 100000);
        err_total++;
        complete_run();
    end

    initial begin
        void'($urandom(9));
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        // reset values and unmapped space
        rd_chk("mode_rst", A_MODE, 32'h0);
        rd_chk("chsel_rst", A_CHS, 32'h0);
        rd_chk("pfm_rst", A_PFM, 32'h0);
        rd_chk("pft_rst", A_PFT, 32'h0);
        rd_chk("unmapped", 8'hfc, 32'h0);
        wr_reg(A_CHS, 8'hfe);
        rd_chk("chsel_mask", A_CHS, 32'h2);
        wr_reg(A_PFM, 8'h3f);
        rd_chk("pfm_mask", A_PFM, 32'h0);
        wr_reg(A_PFT, 8'ha5);
        rd_chk("pft_rw", A_PFT, 32'ha5);
        wr_reg(A_CHS, 8'h00);
        $display("test registers done");
        // start with reference off: first result dropped
        v = 10'($urandom_range(1023));
        levels[9:0] = v;
        wr_reg(A_MODE, 8'hb0);
        wait_irq(150, n, s);
        chk("discard_irq", 32'h0, {31'h0, irq});
        wait_irq(100, n, s);
        chk("second_irq", 32'h1, {31'h0, irq});
        rd_chk("result_ref", A_RES, {16'h0, v, 6'h00});
        wr_reg(A_RES, 8'hff);
        wr_reg(8'hfc, 8'hff);
        rd_chk("result_ro", A_RES, {16'h0, v, 6'h00});
        wr_reg(A_MODE, 8'h00);
        $display("test discard done");
        // reference on, wait for it to settle
        wr_reg(A_MODE, 8'h47);
        rd_chk("mode_mask", A_MODE, 32'h01);
        chk("ref_en", 32'h1, {31'h0, ref_en});
        n = 0;
        do begin
            bus(1'b0, A_STS, 8'h00, rd);
            n++;
        end while (rd[1] !== 1'b1 && n < 800);
        chk("ref_ready", 32'h1, {31'h0, rd[1]});
        // every step time, codes 0 to 2 and 4 to 6, and every channel
        for (int i = 0; i < 8; i++) begin
            run_conv((i % 6 > 2) ? (i % 6) + 1 : (i % 6), i % 4);
        end
        run_conv(4, 3);
        // power-fail compare: both senses, at and just below the threshold
        v = 10'h155;
        levels[9:0] = v;
        wr_reg(A_CHS, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr_reg(A_PFT, 8'h55 + 8'(k % 2));
            wr_reg(A_PFM, 8'h80 | 8'((k / 2) << 6));
            wr_reg(A_MODE, 8'hb1);
            wait_irq(300, n, s);
            chk("pf_irq", (k == 0 || k == 3) ? 32'h1 : 32'h0, {31'h0, irq});
            wr_reg(A_MODE, 8'h01);
        end
        wr_reg(A_PFM, 8'h00);
        $display("test powerfail done");
        // clock enable low freezes the conversion for forty cycles
        wr_reg(A_MODE, 8'hb1);
        wait_irq(300, n, s);
        @(posedge clk_sys_i);
        ce <= 1'b0;
        repeat (40) @(posedge clk_sys_i);
        ce <= 1'b1;
        wait_irq(300, n, s);
        chk("ce_freeze", 32'd96, 32'(n));
        wr_reg(A_MODE, 8'h01);
        $display("test clock enable done");
        // abandon a conversion a third of the way through
        levels[9:0] = 10'h2aa;
        wr_reg(A_MODE, 8'h81);
        repeat (100) @(posedge clk_sys_i);
        wr_reg(A_MODE, 8'h01);
        wait_irq(400, n, s);
        chk("abort_irq", 32'h0, {31'h0, irq});
        rd_chk("abort_result", A_RES, {16'h0, v, 6'h00});
        $display("test abort done");
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
